// File: core/cal_map.svh
`ifndef CAL_MAP_SVH
`define CAL_MAP_SVH
// ----------------------------------------
// Device register offsets (byte registers)
// ----------------------------------------
`define MAIN_INPUT_SELECT_ADDR 8'h06
`define MAIN_OFFSET_COEF_LOW_ADDR 8'h07
`define MAIN_OFFSET_COEF_MID_ADDR 8'h08
`define MAIN_OFFSET_COEF_HIGH_ADDR 8'h09
`define MAIN_GAIN_COEF_LOW_ADDR 8'h0A
`define MAIN_GAIN_COEF_MID_ADDR 8'h0B
`define MAIN_GAIN_COEF_HIGH_ADDR 8'h0C
`define AUX_INPUT_SELECT_ADDR 8'h16
`define AUX_OFFSET_COEF_LOW_ADDR 8'h17
`define AUX_OFFSET_COEF_HIGH_ADDR 8'h18
`define AUX_GAIN_COEF_LOW_ADDR 8'h19
`define AUX_GAIN_COEF_HIGH_ADDR 8'h1A
// ----------------------------------------
// Reset values and constants
// ----------------------------------------
`define MAIN_OFFSET_RESET 24'h000000
`define MAIN_GAIN_RESET 24'h400000
`define AUX_OFFSET_RESET 16'h0000
`define AUX_GAIN_RESET 16'h4000
`define MAIN_GAIN_SHIFT 22
`define AUX_GAIN_SHIFT 14
`define MAIN_OFFSET_ALIGN 8
`define AUX_OFFSET_ALIGN 8
`define CAL_AVG_COUNT 5'h10
`define CAL_AVG_LOG2 4
`define INPUT_OPEN_CODE 8'hFF
`define INPUT_SELECT_RESET 8'h01
// ----------------------------------------
// Host APB register offsets
// ----------------------------------------
`define HOST_CMD_ADDR 12'h000
`define HOST_WDATA_ADDR 12'h004
`define HOST_STATUS_ADDR 12'h008
`define HOST_RDATA_ADDR 12'h00C
`define HOST_MAIN_DATA_ADDR 12'h010
`define HOST_AUX_DATA_ADDR 12'h014
`define HOST_CMD_GO_BIT 31
`define HOST_CMD_WRITE_BIT 30
`define HOST_CMD_CAL_BIT 29
`endif

// File: core/cal_pkg.sv
package cal_pkg;
  // Calibration commands sent over the link
  typedef enum logic [1:0] {
    cmd_none_type_v = 2'h0,
    main_offset_self_cal_cmd = 2'h1,
    main_offset_system_cal_cmd = 2'h2,
    aux_offset_self_cal_cmd = 2'h3
  } cal_cmd_type;
endpackage

// File: core/cal_link_if.sv
`timescale 1ns/1ps
interface cal_link_if;
  // Register access
  logic reg_wr;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  // Commands
  logic cmd_valid;
  logic [1:0] cmd_code;
  logic cal_busy;
  // Conversion data
  logic conversion_ready_flag_n;
  logic [31:0] main_data;
  logic aux_valid;
  logic [23:0] aux_data;
  modport device (input reg_wr, reg_addr, reg_wdata, cmd_valid, cmd_code,
    output reg_rdata, cal_busy, conversion_ready_flag_n, main_data, aux_valid, aux_data);
  modport host (output reg_wr, reg_addr, reg_wdata, cmd_valid, cmd_code,
    input reg_rdata, cal_busy, conversion_ready_flag_n, main_data, aux_valid, aux_data);
endinterface

// File: core/cal_device.sv
// How it works
// - Subtract offset, scale by gain over unity (400000h main, 4000h aux)
// - Saturate main result to signed 32 bits
// - Main offset: 24 bits at 07h-09h
// - Offset coefficient is two's complement
// - Main offset shifted left eight before subtract
// - Chop mode disables main offset subtraction only
// - Aux offset: 16 bits at 17h-18h
// - Aux offset aligned to 24-bit result, subtracted
// - Main gain 24-bit unsigned, 0Ah-0Ch, unity 400000h
// - Aux gain 16-bit unsigned, 19h-1Ah, unity 4000h
// - Host opens main inputs before self-cal
// - Main self-cal averages 16, stores offset
// - Host restores input select after self-cal
// - System cal: host shorts, device averages 16
// - Host opens aux inputs before aux self-cal
// - Aux self-cal averages 16, stores aux offset
// - Ready flag forced high in main cal, held in aux cal; low on next conversion
`timescale 1ns/1ps
`include "cal_map.svh"
module cal_device
  import cal_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link to host
  cal_link_if.device link,
  // Raw converter results, same clock
  input wire logic main_raw_valid,
  input wire logic [31:0] main_raw,
  input wire logic aux_raw_valid,
  input wire logic [23:0] aux_raw,
  input wire logic chop_en,
  // Analog control
  output logic main_short_inputs,
  output logic aux_short_inputs,
  output logic [7:0] main_input_select,
  output logic [7:0] aux_input_select
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef enum logic [3:0] {
    st_idle = 4'b0001,
    st_main = 4'b0010,
    st_aux = 4'b0100,
    st_done = 4'b1000
  } cal_state_type;

  cal_state_type state_q, state_d;
  logic [23:0] main_off_q, main_off_d;
  logic [23:0] main_gain_q, main_gain_d;
  logic [15:0] aux_off_q, aux_off_d;
  logic [15:0] aux_gain_q, aux_gain_d;
  logic [7:0] main_sel_q, main_sel_d;
  logic [7:0] aux_sel_q, aux_sel_d;
  logic [4:0] cnt_q, cnt_d;
  logic signed [35:0] acc_q, acc_d;
  logic self_q, self_d;
  logic [31:0] main_out_q, main_out_d;
  logic [23:0] aux_out_q, aux_out_d;
  logic rdy_n_q, rdy_n_d;
  logic aux_v_q, aux_v_d;
  logic signed [33:0] main_diff;
  logic signed [58:0] main_prod;
  logic signed [36:0] main_scaled;
  logic signed [25:0] aux_diff;
  logic signed [42:0] aux_prod;
  logic signed [28:0] aux_scaled;
  logic signed [31:0] main_avg;
  logic signed [23:0] aux_avg;

  // ----------------------------------------
  // Correction datapath
  // ----------------------------------------
  always_comb begin
    // Offset as signed, left-aligned; chop forces zero
    main_diff = 34'(signed'(main_raw)) -
      (chop_en ? 34'sh0 : 34'(signed'({main_off_q, 8'h00})));
    // Unsigned gain, unity 400000h
    main_prod = 59'(main_diff) * signed'(59'({1'b0, main_gain_q}));
    main_scaled = 37'(main_prod >>> `MAIN_GAIN_SHIFT);
    // Aux aligned offset subtract then gain
    aux_diff = 26'(signed'(aux_raw)) - 26'(signed'({aux_off_q, 8'h00}));
    aux_prod = 43'(aux_diff) * signed'(43'({1'b0, aux_gain_q}));
    aux_scaled = 29'(aux_prod >>> `AUX_GAIN_SHIFT);
    // Averages are the accumulated sum over 16
    main_avg = 32'(acc_q >>> `CAL_AVG_LOG2);
    aux_avg = 24'(acc_q >>> `CAL_AVG_LOG2);
  end

  // ----------------------------------------
  // Next-state and registers
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    main_off_d = main_off_q;
    main_gain_d = main_gain_q;
    aux_off_d = aux_off_q;
    aux_gain_d = aux_gain_q;
    main_sel_d = main_sel_q;
    aux_sel_d = aux_sel_q;
    cnt_d = cnt_q;
    acc_d = acc_q;
    self_d = self_q;
    main_out_d = main_out_q;
    aux_out_d = aux_out_q;
    rdy_n_d = rdy_n_q;
    aux_v_d = 1'b0;
    // Register writes are ignored while calibrating
    if (link.reg_wr && state_q == st_idle) begin
      unique case (link.reg_addr)
        `MAIN_INPUT_SELECT_ADDR: main_sel_d = link.reg_wdata;
        `AUX_INPUT_SELECT_ADDR: aux_sel_d = link.reg_wdata;
        `MAIN_OFFSET_COEF_LOW_ADDR: main_off_d[7:0] = link.reg_wdata;
        `MAIN_OFFSET_COEF_MID_ADDR: main_off_d[15:8] = link.reg_wdata;
        `MAIN_OFFSET_COEF_HIGH_ADDR: main_off_d[23:16] = link.reg_wdata;
        `MAIN_GAIN_COEF_LOW_ADDR: main_gain_d[7:0] = link.reg_wdata;
        `MAIN_GAIN_COEF_MID_ADDR: main_gain_d[15:8] = link.reg_wdata;
        `MAIN_GAIN_COEF_HIGH_ADDR: main_gain_d[23:16] = link.reg_wdata;
        `AUX_OFFSET_COEF_LOW_ADDR: aux_off_d[7:0] = link.reg_wdata;
        `AUX_OFFSET_COEF_HIGH_ADDR: aux_off_d[15:8] = link.reg_wdata;
        `AUX_GAIN_COEF_LOW_ADDR: aux_gain_d[7:0] = link.reg_wdata;
        `AUX_GAIN_COEF_HIGH_ADDR: aux_gain_d[15:8] = link.reg_wdata;
        default: ;
      endcase
    end
    unique case (state_q)
      st_idle: begin
        if (main_raw_valid) begin
          // Clip to signed 32 bits
          if (main_scaled > 37'sh007FFFFFFF) main_out_d = 32'h7FFFFFFF;
          else if (main_scaled < -37'sh0080000000) main_out_d = 32'h80000000;
          else main_out_d = main_scaled[31:0];
          rdy_n_d = 1'b0;
        end else begin
          rdy_n_d = 1'b1;
        end
        if (aux_raw_valid) begin
          // Clip to signed 24 bits
          if (aux_scaled > 29'sh007FFFFF) aux_out_d = 24'h7FFFFF;
          else if (aux_scaled < -29'sh00800000) aux_out_d = 24'h800000;
          else aux_out_d = aux_scaled[23:0];
          aux_v_d = 1'b1;
        end
        if (link.cmd_valid) begin
          cnt_d = 5'h00;
          acc_d = 36'sh0;
          self_d = (link.cmd_code != main_offset_system_cal_cmd);
          unique case (cal_cmd_type'(link.cmd_code))
            main_offset_self_cal_cmd, main_offset_system_cal_cmd: begin
              state_d = st_main;
              rdy_n_d = 1'b1;
            end
            aux_offset_self_cal_cmd: state_d = st_aux;
            default: ;
          endcase
        end
      end
      st_main: begin
        rdy_n_d = 1'b1; // Held inactive throughout
        // Raw filter output, uncorrected, is averaged
        if (main_raw_valid) begin
          acc_d = acc_q + 36'(signed'(main_raw));
          cnt_d = cnt_q + 5'h01;
        end
        if (cnt_q == `CAL_AVG_COUNT) begin
          main_off_d = main_avg[31:8]; // Rescale to coefficient LSBs
          state_d = st_done;
        end
      end
      st_aux: begin
        if (aux_raw_valid) begin
          acc_d = acc_q + 36'(signed'(aux_raw));
          cnt_d = cnt_q + 5'h01;
        end
        if (cnt_q == `CAL_AVG_COUNT) begin
          aux_off_d = aux_avg[23:8];
          state_d = st_done;
        end
      end
      st_done: begin
        // Next conversion reports with new coefficient
        state_d = st_idle;
      end
      default: state_d = st_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= st_idle;
      main_off_q <= `MAIN_OFFSET_RESET;
      main_gain_q <= `MAIN_GAIN_RESET;
      aux_off_q <= `AUX_OFFSET_RESET;
      aux_gain_q <= `AUX_GAIN_RESET;
      main_sel_q <= `INPUT_SELECT_RESET;
      aux_sel_q <= `INPUT_SELECT_RESET;
      cnt_q <= 5'h00;
      acc_q <= 36'sh0;
      self_q <= 1'b0;
      main_out_q <= 32'h00000000;
      aux_out_q <= 24'h000000;
      rdy_n_q <= 1'b1;
      aux_v_q <= 1'b0;
    end else begin
      state_q <= state_d;
      main_off_q <= main_off_d;
      main_gain_q <= main_gain_d;
      aux_off_q <= aux_off_d;
      aux_gain_q <= aux_gain_d;
      main_sel_q <= main_sel_d;
      aux_sel_q <= aux_sel_d;
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      self_q <= self_d;
      main_out_q <= main_out_d;
      aux_out_q <= aux_out_d;
      rdy_n_q <= rdy_n_d;
      aux_v_q <= aux_v_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Readback mux; unmapped reads zero
  always_comb begin
    unique case (link.reg_addr)
      `MAIN_INPUT_SELECT_ADDR: link.reg_rdata = main_sel_q;
      `AUX_INPUT_SELECT_ADDR: link.reg_rdata = aux_sel_q;
      `MAIN_OFFSET_COEF_LOW_ADDR: link.reg_rdata = main_off_q[7:0];
      `MAIN_OFFSET_COEF_MID_ADDR: link.reg_rdata = main_off_q[15:8];
      `MAIN_OFFSET_COEF_HIGH_ADDR: link.reg_rdata = main_off_q[23:16];
      `MAIN_GAIN_COEF_LOW_ADDR: link.reg_rdata = main_gain_q[7:0];
      `MAIN_GAIN_COEF_MID_ADDR: link.reg_rdata = main_gain_q[15:8];
      `MAIN_GAIN_COEF_HIGH_ADDR: link.reg_rdata = main_gain_q[23:16];
      `AUX_OFFSET_COEF_LOW_ADDR: link.reg_rdata = aux_off_q[7:0];
      `AUX_OFFSET_COEF_HIGH_ADDR: link.reg_rdata = aux_off_q[15:8];
      `AUX_GAIN_COEF_LOW_ADDR: link.reg_rdata = aux_gain_q[7:0];
      `AUX_GAIN_COEF_HIGH_ADDR: link.reg_rdata = aux_gain_q[15:8];
      default: link.reg_rdata = 8'h00;
    endcase
  end

  assign link.cal_busy = (state_q != st_idle);
  assign link.conversion_ready_flag_n = rdy_n_q;
  assign link.main_data = main_out_q;
  assign link.aux_valid = aux_v_q;
  assign link.aux_data = aux_out_q;
  // Internal short only for self-calibration
  assign main_short_inputs = (state_q == st_main) && self_q;
  assign aux_short_inputs = (state_q == st_aux);
  assign main_input_select = main_sel_q;
  assign aux_input_select = aux_sel_q;
endmodule

// File: core/cal_host.sv
`timescale 1ns/1ps
`include "cal_map.svh"
module cal_host
  import cal_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link to device
  cal_link_if.host link
);
  // ----------------------------------------
  // Command and capture registers
  // ----------------------------------------
  logic [31:0] wdata_q, wdata_d;
  logic [7:0] rdata_q, rdata_d;
  logic [31:0] main_q, main_d;
  logic [23:0] aux_q, aux_d;
  logic new_main_q, new_main_d;
  logic new_aux_q, new_aux_d;
  logic wr_q, wr_d;
  logic cmd_q, cmd_d;
  logic [1:0] code_q, code_d;
  logic [7:0] addr_q, addr_d;
  logic [7:0] wbyte_q, wbyte_d;
  logic acc_w, acc_r;

  assign acc_w = psel && penable && pwrite;
  assign acc_r = psel && penable && !pwrite;

  // Software opens inputs before self-cal and restores after
  always_comb begin
    wdata_d = wdata_q;
    rdata_d = link.reg_rdata;
    main_d = main_q;
    aux_d = aux_q;
    new_main_d = new_main_q;
    new_aux_d = new_aux_q;
    wr_d = 1'b0;
    cmd_d = 1'b0;
    code_d = code_q;
    addr_d = addr_q;
    wbyte_d = wbyte_q;
    // Reads clear the fresh-data flags; new data wins over the clear
    if (acc_r && paddr == `HOST_MAIN_DATA_ADDR) new_main_d = 1'b0;
    if (acc_r && paddr == `HOST_AUX_DATA_ADDR) new_aux_d = 1'b0;
    if (!link.conversion_ready_flag_n) begin
      main_d = link.main_data;
      new_main_d = 1'b1;
    end
    if (link.aux_valid) begin
      aux_d = link.aux_data;
      new_aux_d = 1'b1;
    end
    if (acc_w && paddr == `HOST_WDATA_ADDR) wdata_d = pwdata;
    if (acc_w && paddr == `HOST_CMD_ADDR && pwdata[`HOST_CMD_GO_BIT]) begin
      addr_d = pwdata[15:8];
      wbyte_d = pwdata[7:0];
      code_d = pwdata[1:0];
      // System cal assumes software already shorted inputs
      if (pwdata[`HOST_CMD_CAL_BIT]) cmd_d = 1'b1;
      else wr_d = pwdata[`HOST_CMD_WRITE_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wdata_q <= 32'h00000000;
      rdata_q <= 8'h00;
      main_q <= 32'h00000000;
      aux_q <= 24'h000000;
      new_main_q <= 1'b0;
      new_aux_q <= 1'b0;
      wr_q <= 1'b0;
      cmd_q <= 1'b0;
      code_q <= 2'h0;
      addr_q <= 8'h00;
      wbyte_q <= 8'h00;
    end else begin
      wdata_q <= wdata_d;
      rdata_q <= rdata_d;
      main_q <= main_d;
      aux_q <= aux_d;
      new_main_q <= new_main_d;
      new_aux_q <= new_aux_d;
      wr_q <= wr_d;
      cmd_q <= cmd_d;
      code_q <= code_d;
      addr_q <= addr_d;
      wbyte_q <= wbyte_d;
    end
  end

  // ----------------------------------------
  // APB read mux, zero-wait answers
  // ----------------------------------------
  always_comb begin
    unique case (paddr)
      `HOST_CMD_ADDR: prdata = {16'h0000, addr_q, wbyte_q};
      `HOST_WDATA_ADDR: prdata = wdata_q;
      `HOST_STATUS_ADDR: prdata = {28'h0000000, new_aux_q, new_main_q,
        link.conversion_ready_flag_n, link.cal_busy};
      `HOST_RDATA_ADDR: prdata = {24'h000000, rdata_q};
      `HOST_MAIN_DATA_ADDR: prdata = main_q;
      `HOST_AUX_DATA_ADDR: prdata = {{8{aux_q[23]}}, aux_q};
      default: prdata = 32'h00000000;
    endcase
  end

  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign link.reg_wr = wr_q;
  assign link.reg_addr = addr_q;
  assign link.reg_wdata = wbyte_q;
  assign link.cmd_valid = cmd_q;
  assign link.cmd_code = code_q;
endmodule

// File: tb/cal_link_sva.sv
`timescale 1ns/1ps
// ----------------------------------------
// Link checker
// ----------------------------------------
module cal_link_sva (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link signals
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_code,
  input wire logic cal_busy,
  input wire logic conversion_ready_flag_n
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Ready flag stays inactive while a calibration runs
  a_busy_ready_idle: assert property (cal_busy |-> conversion_ready_flag_n)
    else $error("ready flag active during calibration");
  a_ready_one_pulse: assert property ($fell(conversion_ready_flag_n) |=>
    conversion_ready_flag_n)
    else $error("ready pulse longer than one cycle");
  a_busy_end_ready: assert property ($fell(cal_busy) |-> conversion_ready_flag_n)
    else $error("ready flag low as calibration ends");
  // A command on an idle device starts a calibration at once
  a_cmd_starts_cal: assert property (cmd_valid && cmd_code != 2'h0 && !cal_busy
    |=> cal_busy)
    else $error("command did not start calibration");
  a_busy_from_cmd: assert property ($rose(cal_busy) |-> $past(cmd_valid))
    else $error("calibration started without command");
  // Sixteen conversions cannot arrive in fewer than eight cycles
  a_busy_min_span: assert property ($rose(cal_busy) |-> cal_busy[*8])
    else $error("calibration ended too early");
  // A written coefficient byte reads back while the address stays
  a_coef_write_back: assert property ((reg_wr && !cal_busy && reg_addr inside
    {8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h17, 8'h18, 8'h19, 8'h1A}) ##1
    (reg_addr == $past(reg_addr)) |-> reg_rdata == $past(reg_wdata))
    else $error("coefficient byte not stored");
  // Gain bytes are frozen against writes during calibration
  a_gain_kept_busy: assert property ((cal_busy && reg_wr && reg_addr inside
    {8'h0A, 8'h0B, 8'h0C, 8'h19, 8'h1A}) ##1 (reg_addr == $past(reg_addr)) |-> $stable(reg_rdata))
    else $error("gain byte changed during calibration");
  c_cal_start: cover property ($rose(cal_busy));
  c_ready_pulse: cover property ($fell(conversion_ready_flag_n));
  c_busy_write: cover property (cal_busy && reg_wr);
endmodule

// File: tb/test_adc_offset_gain_calibration.sv
`timescale 1ns/1ps
`include "cal_map.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module test_adc_offset_gain_calibration;
  import cal_pkg::*;
  // ----------------------------------------
  // Stimulus and instances
  // ----------------------------------------
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, r, mraw = 32'h0;
  logic pready, pslverr, msh, ash, mv = 1'b0, av = 1'b0, chop = 1'b0;
  logic [23:0] araw = 24'h0;
  logic [7:0] msel, asel, b;
  int n_fail = 0, n_tests = 0, n_rdy = 0;
  cal_link_if link ();
  cal_device i_cal_device (.pclk(pclk), .presetn(presetn), .link(link), .main_raw_valid(mv),
    .main_raw(mraw), .aux_raw_valid(av), .aux_raw(araw), .chop_en(chop),
    .main_short_inputs(msh), .aux_short_inputs(ash), .main_input_select(msel),
    .aux_input_select(asel));
  cal_host i_cal_host (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link(link));
  cal_link_sva i_cal_link_sva (.pclk(pclk), .presetn(presetn), .reg_wr(link.reg_wr),
    .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata), .reg_rdata(link.reg_rdata),
    .cmd_valid(link.cmd_valid), .cmd_code(link.cmd_code), .cal_busy(link.cal_busy),
    .conversion_ready_flag_n(link.conversion_ready_flag_n));
  // Clock and count of ready pulses
  always #2 pclk = ~pclk;
  always @(posedge pclk) if (link.conversion_ready_flag_n === 1'b0) n_rdy++;
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Subtract aligned offset, scale, clip to w bits
  function automatic longint exp_out(longint x, longint o, longint g, int gs, int w, bit c);
    longint d, lim;
    lim = longint'(1) <<< (w - 1);
    d = ((x - (c ? 0 : o <<< 8)) * g) >>> gs;
    if (d >= lim) d = lim - 1;
    if (d < -lim) d = -lim;
    return d;
  endfunction
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait states end only on pready; a hang is left to the watchdog
    while (pready !== 1'b1) @(posedge pclk);
    r = prdata;
    `CHK("pready", 1'b1, pready)
    `CHK("pslverr", 1'b0, pslverr)
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic dev_wr(input logic [7:0] a, input logic [7:0] v);
    apb(1'b1, `HOST_CMD_ADDR, {2'b11, 14'h0, a, v});
    repeat (3) @(posedge pclk);
  endtask
  // Device reads pass through the host with a fixed lag
  task automatic dev_rd(input logic [7:0] a);
    apb(1'b1, `HOST_CMD_ADDR, {2'b10, 14'h0, a, 8'h00});
    repeat (3) @(posedge pclk);
    apb(1'b0, `HOST_RDATA_ADDR, 32'h0);
    b = r[7:0];
  endtask
  task automatic set_coef(input logic [7:0] a, input logic [23:0] v, input int nb);
    for (int i = 0; i < nb; i++) dev_wr(a + 8'(i), v[8*i +: 8]);
  endtask
  task automatic conv(input logic aux, input logic [31:0] x);
    mraw <= x;
    araw <= x[23:0];
    mv <= !aux;
    av <= aux;
    @(posedge pclk);
    mv <= 1'b0;
    av <= 1'b0;
    repeat (3) @(posedge pclk);
    apb(1'b0, aux ? `HOST_AUX_DATA_ADDR : `HOST_MAIN_DATA_ADDR, 32'h0);
  endtask
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [7:0] a [12] = '{8'h07, 8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C, 8'h17, 8'h18, 8'h19,
      8'h1A, 8'h06, 8'h16};
    logic [7:0] e [12] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 8'h40,
      8'h01, 8'h01};
    for (int i = 0; i < 12; i++) begin
      dev_rd(a[i]);
      `CHK("reset byte", e[i], b)
    end
  endtask
  // Last case reuses offset 0ABCDE with chop on, offset must drop out
  task automatic t_main;
    logic [23:0] o [7] = '{24'h000001, 24'hFFFFFF, 24'h123456, 24'h800000, 24'h7FFFFF, 24'h0ABCDE,
      24'h0ABCDE};
    logic [23:0] g [7] = '{24'h400000, 24'h400000, 24'h433333, 24'h400000, 24'h3CCCCC,
      24'h7FFFFF, 24'h400000};
    logic [31:0] x [7] = '{32'h00000000, 32'h00000000, 32'h12345678, 32'h7FFFFFFF,
      32'h80000000, 32'h40000000, 32'h12345678};
    longint e;
    for (int i = 0; i < 7; i++) begin
      chop <= (i == 6);
      set_coef(`MAIN_OFFSET_COEF_LOW_ADDR, o[i], 3);
      set_coef(`MAIN_GAIN_COEF_LOW_ADDR, g[i], 3);
      conv(1'b0, x[i]);
      e = exp_out($signed(x[i]), $signed(o[i]), g[i], 22, 32, i == 6);
      `CHK("main data", e[31:0], r)
    end
    for (int j = 0; j < 3; j++) begin
      dev_rd(`MAIN_OFFSET_COEF_LOW_ADDR + 8'(j));
      `CHK("main offset byte", o[6][8*j +: 8], b)
    end
  endtask
  task automatic t_aux;
    logic [15:0] o [4] = '{16'h0001, 16'hFFFF, 16'h8000, 16'h1234};
    logic [15:0] g [4] = '{16'h4000, 16'h4000, 16'h5000, 16'h7FFF};
    logic [23:0] x [4] = '{24'h000000, 24'h000000, 24'h7FFFFF, 24'h800000};
    longint e;
    for (int i = 0; i < 4; i++) begin
      set_coef(`AUX_OFFSET_COEF_LOW_ADDR, {8'h00, o[i]}, 2);
      set_coef(`AUX_GAIN_COEF_LOW_ADDR, {8'h00, g[i]}, 2);
      conv(1'b1, {8'h00, x[i]});
      e = exp_out($signed(x[i]), $signed(o[i]), g[i], 14, 24, 1'b0);
      `CHK("aux data", e[31:0], r)
    end
  endtask
  // A gain write that must be ignored, sixteen raw results, then new data
  task automatic t_cal(input logic [1:0] code);
    longint s, e;
    int n, k;
    logic aux;
    logic [31:0] x;
    logic [7:0] sel;
    aux = (code == aux_offset_self_cal_cmd);
    sel = aux ? `AUX_INPUT_SELECT_ADDR : `MAIN_INPUT_SELECT_ADDR;
    s = 0;
    n = 0;
    k = n_rdy;
    if (code != main_offset_system_cal_cmd) dev_wr(sel, `INPUT_OPEN_CODE);
    apb(1'b1, `HOST_CMD_ADDR, {3'b101, 27'h0, code});
    repeat (2) @(posedge pclk);
    `CHK("busy", 1'b1, link.cal_busy)
    `CHK("short", code != main_offset_system_cal_cmd, aux ? ash : msh)
    // Host status shows busy with the ready flag held inactive
    apb(1'b0, `HOST_STATUS_ADDR, 32'h0);
    `CHK("status busy", 2'b11, r[1:0])
    dev_wr(aux ? `AUX_GAIN_COEF_LOW_ADDR : `MAIN_GAIN_COEF_LOW_ADDR, 8'h5A);
    for (int i = 0; i < 16; i++) begin
      x = 32'hFFFED000 + 32'(i * 37);
      s += aux ? longint'($signed(x[23:0])) : longint'($signed(x));
      conv(aux, x);
    end
    while (link.cal_busy !== 1'b0 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    `CHK("cal done", 1'b1, n < 50)
    `CHK("ready count", k, n_rdy)
    e = (s >>> 4) >>> 8;
    for (int j = 0; j < (aux ? 2 : 3); j++) begin
      dev_rd((aux ? `AUX_OFFSET_COEF_LOW_ADDR : `MAIN_OFFSET_COEF_LOW_ADDR) + 8'(j));
      `CHK("cal offset byte", e[8*j +: 8], b)
    end
    dev_rd(aux ? `AUX_GAIN_COEF_LOW_ADDR : `MAIN_GAIN_COEF_LOW_ADDR);
    `CHK("gain kept", 8'h00, b)
    conv(aux, 32'h00100000);
    e = aux ? exp_out(64'h100000, $signed(e[15:0]), 64'h4000, 14, 24, 1'b0)
      : exp_out(64'h100000, $signed(e[23:0]), 64'h400000, 22, 32, 1'b0);
    `CHK("post cal data", e[31:0], r)
    `CHK("ready after cal", k + (aux ? 0 : 1), n_rdy)
    dev_wr(sel, 8'h01);
    `CHK("select restored", 8'h01, aux ? asel : msel)
  endtask
  // ----------------------------------------
  // Sequence, watchdog and verdict
  // ----------------------------------------
  task automatic end_of_test;
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_main;
    t_aux;
    chop <= 1'b0;
    set_coef(`MAIN_GAIN_COEF_LOW_ADDR, 24'h400000, 3);
    set_coef(`AUX_GAIN_COEF_LOW_ADDR, 24'h004000, 2);
    t_cal(main_offset_self_cal_cmd);
    t_cal(main_offset_system_cal_cmd);
    t_cal(aux_offset_self_cal_cmd);
    end_of_test;
  end
  // A hang counts as a mismatch
  initial begin
    repeat (40000) @(posedge pclk);
    n_fail++;
    end_of_test;
  end
endmodule
